// File: core/return_stack_defines.svh
// Offsets, field positions, reset values and widths of the return-address stack
`ifndef RETURN_STACK_DEFINES_SVH
`define RETURN_STACK_DEFINES_SVH

`define RS_ADDR_W          8
`define RS_DATA_W          8
`define RS_PC_W            9
`define RS_IDX_W           2
`define RS_DEPTH           4
`define RS_DEPTH_CNT_W     3

`define RS_INDEX_REG_ADDR  8'hdf
`define RS_SLOT_BASE_ADDR  8'hf0
`define RS_SLOT_TOP_ADDR   8'hff
`define RS_SLOT_ADDR_MASK  8'hf0

`define RS_IRQ_ALLOW_BIT   7
`define RS_INDEX_MSB       1
`define RS_INDEX_LSB       0
`define RS_PC8_BIT         0

`define RS_INDEX_RESET     2'h3
`define RS_IRQ_RESET       1'h0
`define RS_SLOT_RESET      9'h000
`define RS_DEPTH_FULL      3'h4

`endif

// File: core/return_stack_pkg.sv
// Types shared by the return-address stack files
package return_stack_pkg;
    typedef logic [1:0] stack_index_t;
    typedef logic [8:0] saved_pc_t;
    typedef logic [2:0] stack_depth_t;
endpackage

// File: core/stack_slot.sv
// One return-address entry with push and byte-wise software access
`timescale 1ns/10ps
`include "return_stack_defines.svh"

module stack_slot #(
    parameter int PC_W = `RS_PC_W
) (
    // Clock and reset
    input  wire logic            i_core_clk,
    input  wire logic            i_reset,
    input  wire logic            i_clk_en,
    // Hardware push
    input  wire logic            i_push_wr,
    input  wire logic [PC_W-1:0] i_push_pc,
    // Software byte writes
    input  wire logic            i_low_wr,
    input  wire logic            i_high_wr,
    input  wire logic [7:0]      i_wdata,
    // Stored value
    output logic      [PC_W-1:0] o_value
);

    // Refuse widths that the byte split below cannot serve
    if (PC_W != 9) begin : g_bad_width
        $error("stack_slot serves a 9-bit program counter only");
    end

    // Push wins over a software byte write in the same cycle
    wire logic [PC_W-1:0] next_value = i_push_wr ? i_push_pc :
                                       i_low_wr  ? {o_value[8], i_wdata} :
                                       i_high_wr ? {i_wdata[`RS_PC8_BIT], o_value[7:0]} :
                                       o_value;

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_value <= `RS_SLOT_RESET; // RULE12
        end else if (i_clk_en) begin
            o_value <= next_value; // RULE9
        end
    end

    a_push_capture: assert property (@(posedge i_core_clk) disable iff (i_reset) // RULE4
        (i_clk_en && i_push_wr) |=> (o_value == $past(i_push_pc)))
        else $error("slot did not capture pushed pc");

endmodule

// File: core/return_address_stack.sv
// Four-level return-address stack with index and irq-allow register
//
// Notes on behaviour
// [RULE1] Four entries, last in first out
// [RULE2] Two-bit index, nine-bit entries
// [RULE3] Push decrements index, pop increments it
// [RULE4] Call and interrupt entry push the pc
// [RULE5] Both return kinds pop the stack
// [RULE6] Pop returns top entry to pc
// [RULE7] Index sequence 11,10,01,00,11; fifth push overflows
// [RULE8] Register bit 7 is global irq allow
// [RULE9] Entries readable as high and low bytes
// [RULE10] Software writes 00000011 to index first
// [RULE11] Registers sit in bank 0 system area
// [RULE12] Reset: index 11, irq off, entries zero
`timescale 1ns/10ps
`include "return_stack_defines.svh"

module return_address_stack #(
    parameter int DEPTH = `RS_DEPTH,
    parameter int PC_W  = `RS_PC_W
) (
    // Clock, reset and enable
    input  wire logic            i_core_clk,
    input  wire logic            i_reset,
    input  wire logic            i_clk_en,
    // Sequencer events
    input  wire logic            i_push,
    input  wire logic [PC_W-1:0] i_pc,
    input  wire logic            i_subroutine_return_op,
    input  wire logic            i_interrupt_return_op,
    // Return path
    output logic      [PC_W-1:0] o_ret_pc,
    output logic                 o_ret_valid,
    output logic                 o_stack_overflow,
    output logic                 o_global_irq_allow,
    // Bank 0 system register port
    input  wire logic [7:0]      i_reg_addr,
    input  wire logic            i_reg_wr,
    input  wire logic [7:0]      i_reg_wdata,
    input  wire logic            i_reg_rd,
    output logic      [7:0]      o_reg_rdata
);

    // Refuse sizes that the two-bit index and byte map cannot serve
    if (DEPTH != 4 || PC_W != 9) begin : g_bad_params
        $error("return_address_stack serves four 9-bit entries only");
    end

    // ************************************************************
    // Index, depth and decode
    // ************************************************************
    return_stack_pkg::stack_index_t call_stack_index; // RULE2
    return_stack_pkg::stack_depth_t depth;
    logic                           global_irq_allow;
    wire logic [PC_W-1:0]           slot_val [DEPTH];

    wire logic pop      = i_subroutine_return_op | i_interrupt_return_op; // RULE5
    wire logic do_push  = i_clk_en & i_push; // RULE4
    wire logic do_pop   = i_clk_en & pop & ~i_push;
    wire logic full     = (depth == `RS_DEPTH_FULL);

    // Push writes slot ~index; pop reads slot ~(index + 1)
    wire return_stack_pkg::stack_index_t push_slot = ~call_stack_index;  // RULE7
    wire return_stack_pkg::stack_index_t pop_index = call_stack_index + 2'h1;
    wire return_stack_pkg::stack_index_t pop_slot  = ~pop_index;

    wire logic index_hit = (i_reg_addr == `RS_INDEX_REG_ADDR); // RULE11
    wire logic slot_hit  = ((i_reg_addr & `RS_SLOT_ADDR_MASK) == `RS_SLOT_BASE_ADDR)
                           && (i_reg_addr[3] == 1'b0);
    wire logic [1:0] byte_slot = i_reg_addr[2:1];
    wire logic       byte_high = i_reg_addr[0];
    wire logic sw_index_wr = i_clk_en & i_reg_wr & index_hit;
    wire logic sw_slot_wr  = i_clk_en & i_reg_wr & slot_hit;

    wire return_stack_pkg::stack_index_t wr_index = i_reg_wdata[`RS_INDEX_MSB:`RS_INDEX_LSB];
    wire return_stack_pkg::stack_depth_t wr_depth =
        (wr_index == `RS_INDEX_RESET) ? 3'h0 : {1'b0, 2'h3 - wr_index};

    // Hardware push or pop wins over a software index write
    wire return_stack_pkg::stack_index_t next_index =
        do_push ? call_stack_index - 2'h1 :
        do_pop  ? pop_index :
        sw_index_wr ? wr_index : call_stack_index; // RULE3
    wire return_stack_pkg::stack_depth_t next_depth =
        do_push ? (full ? depth : depth + 3'h1) :
        do_pop  ? ((depth == 3'h0) ? depth : depth - 3'h1) :
        sw_index_wr ? wr_depth : depth;

    // ************************************************************
    // State registers
    // ************************************************************
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            call_stack_index <= `RS_INDEX_RESET; // RULE12
            depth            <= 3'h0;
            global_irq_allow <= `RS_IRQ_RESET;
        end else if (i_clk_en) begin
            call_stack_index <= next_index; // RULE3
            depth            <= next_depth;
            if (sw_index_wr) begin
                global_irq_allow <= i_reg_wdata[`RS_IRQ_ALLOW_BIT]; // RULE8
            end
        end
    end

    assign o_global_irq_allow = global_irq_allow;

    // ************************************************************
    // Entries
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_slot
            stack_slot #(.PC_W(PC_W)) u_slot (
                .i_core_clk (i_core_clk),
                .i_reset    (i_reset),
                .i_clk_en   (i_clk_en),
                .i_push_wr  (do_push && push_slot == 2'(g)), // RULE1
                .i_push_pc  (i_pc),
                .i_low_wr   (sw_slot_wr && byte_slot == 2'(g) && !byte_high),
                .i_high_wr  (sw_slot_wr && byte_slot == 2'(g) && byte_high),
                .i_wdata    (i_reg_wdata),
                .o_value    (slot_val[g])
            );
        end
    endgenerate

    // ************************************************************
    // Return path and read port
    // ************************************************************
    wire logic [PC_W-1:0] sel_slot = slot_val[byte_slot];
    wire logic [7:0] rd_byte =
        index_hit ? {global_irq_allow, 5'h00, call_stack_index} :
        slot_hit  ? (byte_high ? {7'h00, sel_slot[8]} : sel_slot[7:0]) : // RULE9
        8'h00;

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_ret_pc         <= `RS_SLOT_RESET;
            o_ret_valid      <= 1'b0;
            o_stack_overflow <= 1'b0;
            o_reg_rdata      <= 8'h00;
        end else if (i_clk_en) begin
            o_ret_valid      <= do_pop;
            o_stack_overflow <= do_push & full; // RULE7
            if (do_pop) begin
                o_ret_pc <= slot_val[pop_slot]; // RULE6
            end
            if (i_reg_rd) begin
                o_reg_rdata <= rd_byte;
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_push_index_dec: assert property (@(posedge i_core_clk) disable iff (i_reset) // RULE3
        do_push |=> (call_stack_index == $past(call_stack_index) - 2'h1))
        else $error("push did not decrement index");

    a_pop_index_inc: assert property (@(posedge i_core_clk) disable iff (i_reset) // RULE3
        do_pop |=> (call_stack_index == $past(call_stack_index) + 2'h1))
        else $error("pop did not increment index");

    a_pop_returns_top: assert property (@(posedge i_core_clk) disable iff (i_reset) // RULE6
        (do_push ##1 (i_clk_en && pop && !i_push)) |=> (o_ret_valid && o_ret_pc == $past(i_pc, 2)))
        else $error("pop did not return last pushed pc");

    a_overflow_flag: assert property (@(posedge i_core_clk) disable iff (i_reset) // RULE7
        (do_push && depth == 3'h4 && call_stack_index == 2'h3)
        |=> (o_stack_overflow && call_stack_index == 2'h2))
        else $error("fifth push not flagged");

    a_depth_index_match: assert property (@(posedge i_core_clk) disable iff (i_reset) // RULE7
        (depth == 3'h1 || depth == 3'h2 || depth == 3'h3) |-> (call_stack_index == 2'h3 - depth[1:0]))
        else $error("index does not match depth");

    a_reset_state: assert property (@(posedge i_core_clk) disable iff (i_reset) // RULE12
        $past(i_reset) |-> (call_stack_index == 2'h3 && !o_global_irq_allow && depth == 3'h0))
        else $error("reset values wrong");

    a_irq_allow_write: assert property (@(posedge i_core_clk) disable iff (i_reset) // RULE8
        sw_index_wr |=> (o_global_irq_allow == $past(i_reg_wdata[7])))
        else $error("irq allow bit not written");

    a_index_read: assert property (@(posedge i_core_clk) disable iff (i_reset) // RULE11
        (i_clk_en && i_reg_rd && index_hit && !sw_index_wr && !do_push && !do_pop)
        |=> (o_reg_rdata[1:0] == call_stack_index && o_reg_rdata[6:2] == 5'h00))
        else $error("index read wrong");

    a_high_byte_read: assert property (@(posedge i_core_clk) disable iff (i_reset) // RULE9
        (i_clk_en && i_reg_rd && slot_hit && byte_high) |=> (o_reg_rdata[7:1] == 7'h00))
        else $error("high byte upper bits not zero");

endmodule

// File: sim/sequencer_model.sv
// Behavioural core sequencer that issues calls, interrupt entries and returns
`timescale 1ns/10ps

module sequencer_model (
    // Clock
    input  wire logic       i_core_clk,
    // Stack events
    output logic            o_push,
    output logic [8:0]      o_pc,
    output logic            o_sub_ret,
    output logic            o_int_ret
);
    initial begin
        o_push = 1'b0;
        o_pc = 9'h000;
        o_sub_ret = 1'b0;
        o_int_ret = 1'b0;
    end

    // A call and an interrupt entry look alike here: one push of the pc
    task automatic save_pc(input logic [8:0] pc);
        @(negedge i_core_clk);
        o_push = 1'b1;
        o_pc = pc;
        @(negedge i_core_clk);
        o_push = 1'b0;
        o_pc = ~pc;
    endtask

    task automatic restore_pc(input logic intr);
        @(negedge i_core_clk);
        o_sub_ret = !intr;
        o_int_ret = intr;
        @(negedge i_core_clk);
        o_sub_ret = 1'b0;
        o_int_ret = 1'b0;
    endtask
endmodule

// File: sim/return_address_stack_test.sv
// Self-checking bench for the return-address stack
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end

module return_address_stack_test;
    // ****************************************
    // Stimulus and checks
    // ****************************************
    logic                          i_core_clk = 1'b0;
    logic                          i_reset    = 1'b1;
    logic [7:0]                    addr       = 8'h00;
    logic                          wr         = 1'b0;
    logic [7:0]                    wdata      = 8'h00;
    logic                          rd         = 1'b0;
    logic                          clk_en     = 1'b1;
    logic                          push, sret, iret, ret_valid, ovf, irq;
    return_stack_pkg::saved_pc_t   pc, ret_pc;
    logic [7:0]                    rdata;
    int                            failures = 0;
    int                            checked  = 0;
    int                            cycles   = 0;
    return_stack_pkg::saved_pc_t   pcs [4] = '{9'h1a5, 9'h05a, 9'h100, 9'h0ff};

    always #10 i_core_clk = ~i_core_clk;

    sequencer_model u_sequencer_model (.i_core_clk(i_core_clk), .o_push(push), .o_pc(pc),
        .o_sub_ret(sret), .o_int_ret(iret));

    return_address_stack u_return_address_stack (.i_core_clk(i_core_clk), .i_reset(i_reset),
        .i_clk_en(clk_en), .i_push(push), .i_pc(pc), .i_subroutine_return_op(sret),
        .i_interrupt_return_op(iret), .o_ret_pc(ret_pc), .o_ret_valid(ret_valid),
        .o_stack_overflow(ovf), .o_global_irq_allow(irq), .i_reg_addr(addr), .i_reg_wr(wr),
        .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata));

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_core_clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge i_core_clk);
        wr = 1'b0;
        wdata = ~d;
    endtask

    task automatic reg_rd(input logic [7:0] a);
        @(negedge i_core_clk);
        addr = a;
        rd = 1'b1;
        @(negedge i_core_clk);
        rd = 1'b0;
    endtask

    task automatic end_of_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic t_reset();
        reg_rd(8'hdf);
        `CHK(rdata, 8'h03)
        reg_rd(8'hf7);
        `CHK(rdata, 8'h00)
        `CHK(irq, 1'b0)
        $display("t_reset done");
    endtask

    task automatic t_lifo();
        reg_wr(8'hdf, 8'h03);
        for (int i = 0; i < 4; i++) begin
            u_sequencer_model.save_pc(pcs[i]);
            reg_rd(8'hdf);
            `CHK(rdata, {6'h00, 2'(2 - i)})
        end
        reg_rd(8'hf0);
        `CHK(rdata, pcs[0][7:0])
        reg_rd(8'hf1);
        `CHK(rdata, {7'h00, pcs[0][8]})
        for (int i = 3; i >= 0; i--) begin
            u_sequencer_model.restore_pc(i[0]);
            `CHK(ret_valid, 1'b1)
            `CHK(ret_pc, pcs[i])
        end
        reg_rd(8'hdf);
        `CHK(rdata, 8'h03)
        $display("t_lifo done");
    endtask

    task automatic t_overflow();
        repeat (4) u_sequencer_model.save_pc(9'h011);
        `CHK(ovf, 1'b0)
        u_sequencer_model.save_pc(9'h122);
        `CHK(ovf, 1'b1)
        reg_rd(8'hdf);
        `CHK(rdata, 8'h02)
        `CHK(ovf, 1'b0)
        $display("t_overflow done");
    endtask

    task automatic t_irq_allow();
        reg_wr(8'hdf, 8'h83);
        reg_rd(8'hdf);
        `CHK(rdata, 8'h83)
        `CHK(irq, 1'b1)
        reg_wr(8'hdf, 8'h03);
        `CHK(irq, 1'b0)
        reg_rd(8'h50);
        `CHK(rdata, 8'h00)
        $display("t_irq_allow done");
    endtask

    // One entry written by software, then popped back as a pc
    task automatic t_slot_write();
        reg_wr(8'hdf, 8'h02);
        reg_wr(8'hf0, 8'hab);
        reg_wr(8'hf1, 8'hfe);
        reg_rd(8'hf1);
        `CHK(rdata, 8'h00)
        u_sequencer_model.restore_pc(1'b0);
        `CHK(ret_pc, 9'h0ab)
        @(negedge i_core_clk);
        `CHK(ret_valid, 1'b0)
        $display("t_slot_write done");
    endtask

    // Push, write and read while the enable is low must all be ignored
    task automatic t_freeze();
        reg_rd(8'hdf);
        `CHK(rdata, 8'h03)
        @(negedge i_core_clk);
        clk_en = 1'b0;
        u_sequencer_model.save_pc(9'h0c3);
        reg_wr(8'hdf, 8'h80);
        reg_rd(8'hf0);
        `CHK(rdata, 8'h03)
        `CHK(irq, 1'b0)
        @(negedge i_core_clk);
        clk_en = 1'b1;
        reg_rd(8'hdf);
        `CHK(rdata, 8'h03)
        reg_rd(8'hf0);
        `CHK(rdata, 8'hab)
        $display("t_freeze done");
    endtask

    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            end_of_test();
        end
    end

    initial begin
        repeat (6) @(negedge i_core_clk);
        i_reset = 1'b0;
        t_reset();
        t_lifo();
        t_overflow();
        t_irq_allow();
        t_slot_write();
        t_freeze();
        end_of_test();
    end
endmodule
